// [shared/mies_pkg.sv]
// shared constants, register map and opcode list of the instruction execution block
package mies_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WREG = 8'h08;
  localparam logic [7:0] REG_TBL = 8'h0c;
  localparam logic [7:0] REG_PAGE = 8'h10;
  localparam logic [7:0] REG_MADDR = 8'h14;
  localparam logic [7:0] REG_MDATA = 8'h18;
  localparam logic [7:0] REG_PADDR = 8'h1c;
  localparam logic [7:0] REG_PDATA = 8'h20;

  // field positions
  localparam int CMD_IMM_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_BIT_LSB = 16;
  localparam int CMD_OP_LSB = 24;
  localparam int STAT_BUSY = 8;
  localparam int STAT_SKIP = 9;
  localparam int TBL_HIGH_LSB = 8;
  localparam int FLAG_C = 0;
  localparam int FLAG_HALF_CARRY = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_SIGNED_LIMIT = 3;

  // memories and values
  localparam int MEM_DEPTH = 88;
  localparam logic [6:0] MEM_LIMIT = 7'h58;
  localparam int ROM_DEPTH = 2048;
  localparam logic [2:0] FINAL_PAGE = 3'h7;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [5:0] FLAG_RESET = 6'h00;
  // one instruction cycle is four ref_clk cycles
  localparam logic [1:0] CYC_DIV_LAST = 2'h3;

  typedef enum logic [4:0] {
    OP_DEC_W_SKIP, OP_SET, OP_SET_BIT, OP_INC_SKIP, OP_INC_W_SKIP,
    OP_SKIP_BIT_SET, OP_SKIP_BIT_CLR, OP_SKIP_ZERO, OP_LOAD_SKIP,
    OP_SUB, OP_SUB_STORE, OP_SUB_IMM, OP_SWAP, OP_SWAP_W,
    OP_TBL_CUR, OP_TBL_FINAL, OP_XOR, OP_XOR_STORE, OP_XOR_IMM
  } mies_op_t;
endpackage : mies_pkg

// [shared/mies_alu_if.sv]
// operand and result bundle between the sequencer and the execute unit
`timescale 1ns/100ps
interface mies_alu_if;
  import mies_pkg::*;
  mies_op_t op;
  logic [7:0] mem_val;
  logic [7:0] wreg;
  logic [7:0] imm;
  logic [2:0] bit_sel;
  logic [5:0] flags_in;
  logic [13:0] rom_word;
  logic [7:0] result;
  logic mem_we;
  logic wreg_we;
  logic tbl_we;
  logic [5:0] flags_out;
  logic skip;
  modport alu (input op, mem_val, wreg, imm, bit_sel, flags_in, rom_word,
               output result, mem_we, wreg_we, tbl_we, flags_out, skip);
  modport core (output op, mem_val, wreg, imm, bit_sel, flags_in, rom_word,
                input result, mem_we, wreg_we, tbl_we, flags_out, skip);
endinterface : mies_alu_if

// [src/mies_alu.sv]
// combinational execute unit: results, write enables, flags and skip decision
`timescale 1ns/100ps
module mies_alu (
  mies_alu_if.alu bus
);
  import mies_pkg::*;

  logic [7:0] rhs;
  logic [8:0] sub_sum;
  logic [4:0] sub_low;
  logic [7:0] inc_val;
  logic [7:0] dec_val;
  logic [7:0] xor_val;
  logic [7:0] swap_val;

  // shared arithmetic; immediate forms take the operand from the command word
  always_comb
  begin
    rhs = (bus.op == OP_SUB_IMM || bus.op == OP_XOR_IMM) ? bus.imm : bus.mem_val;
    sub_sum = {1'b0, bus.wreg} + {1'b0, ~rhs} + 9'h001;
    sub_low = {1'b0, bus.wreg[3:0]} + {1'b0, ~rhs[3:0]} + 5'h01;
    inc_val = bus.mem_val + BYTE_ONE;
    dec_val = bus.mem_val - BYTE_ONE;
    xor_val = bus.wreg ^ rhs;
    swap_val = {bus.mem_val[3:0], bus.mem_val[7:4]};
  end

  // per-opcode effects; flags pass through unless the opcode names them
  always_comb
  begin
    bus.result = BYTE_ZERO;
    bus.mem_we = 1'b0;
    bus.wreg_we = 1'b0;
    bus.tbl_we = 1'b0;
    bus.flags_out = bus.flags_in;
    bus.skip = 1'b0;
    case (bus.op)
      OP_DEC_W_SKIP:
      begin
        bus.result = dec_val;
        bus.wreg_we = 1'b1;
        bus.skip = (dec_val == BYTE_ZERO);
      end
      OP_SET:
      begin
        bus.result = BYTE_ONES;
        bus.mem_we = 1'b1;
      end
      OP_SET_BIT:
      begin
        bus.result = bus.mem_val | (BYTE_ONE << bus.bit_sel);
        bus.mem_we = 1'b1;
      end
      OP_INC_SKIP:
      begin
        bus.result = inc_val;
        bus.mem_we = 1'b1;
        bus.skip = (inc_val == BYTE_ZERO);
      end
      OP_INC_W_SKIP:
      begin
        bus.result = inc_val;
        bus.wreg_we = 1'b1;
        bus.skip = (inc_val == BYTE_ZERO);
      end
      OP_SKIP_BIT_SET: bus.skip = bus.mem_val[bus.bit_sel];
      OP_SKIP_BIT_CLR: bus.skip = !bus.mem_val[bus.bit_sel];
      OP_SKIP_ZERO: bus.skip = (bus.mem_val == BYTE_ZERO);
      OP_LOAD_SKIP:
      begin
        bus.result = bus.mem_val;
        bus.wreg_we = 1'b1;
        bus.skip = (bus.mem_val == BYTE_ZERO);
      end
      OP_SUB, OP_SUB_STORE, OP_SUB_IMM:
      begin
        bus.result = sub_sum[7:0];
        bus.mem_we = (bus.op == OP_SUB_STORE);
        bus.wreg_we = (bus.op != OP_SUB_STORE);
        bus.flags_out[FLAG_C] = sub_sum[8];
        bus.flags_out[FLAG_HALF_CARRY] = sub_low[4];
        bus.flags_out[FLAG_Z] = (sub_sum[7:0] == BYTE_ZERO);
        // signed overflow: operands differ in sign and result sign leaves wreg's
        bus.flags_out[FLAG_SIGNED_LIMIT] = (bus.wreg[7] != rhs[7]) && (sub_sum[7] != bus.wreg[7]);
      end
      OP_SWAP:
      begin
        bus.result = swap_val;
        bus.mem_we = 1'b1;
      end
      OP_SWAP_W:
      begin
        bus.result = swap_val;
        bus.wreg_we = 1'b1;
      end
      OP_TBL_CUR, OP_TBL_FINAL:
      begin
        bus.result = bus.rom_word[7:0];
        bus.mem_we = 1'b1;
        bus.tbl_we = 1'b1;
      end
      OP_XOR, OP_XOR_STORE, OP_XOR_IMM:
      begin
        bus.result = xor_val;
        bus.mem_we = (bus.op == OP_XOR_STORE);
        bus.wreg_we = (bus.op != OP_XOR_STORE);
        bus.flags_out[FLAG_Z] = (xor_val == BYTE_ZERO);
      end
      default: bus.skip = 1'b0;
    endcase
  end
endmodule : mies_alu

// [src/mies_core.sv]
// instruction execution block with its memories, sequencer and register slave
//
// What this block does
// - decrement to work register: memory kept, one cycle when nonzero
// - any skip adds one dummy instruction cycle before the block goes idle
// - whole-byte set writes ff to memory, flags unchanged
// - bit set forces one selected bit, other bits and flags kept
// - increment stores sum to memory, skips when it wraps to zero
// - increment to work register, memory kept, skip when zero
// - skip when the selected memory bit is one
// - skip when the selected memory bit is zero
// - skip when the memory byte is zero, nothing modified
// - load byte into work register, skip when it is zero
// - subtract memory from work register, result in work register, four flags
// - subtract memory from work register, result stored in memory
// - subtract immediate from work register, four flags updated
// - swap nibbles of memory byte in place, flags kept
// - swapped memory byte goes to work register, memory kept
// - table read from current page: low byte to memory, high to latch
// - table read from the final program page at the pointer offset
// - xor memory into work register, only zero flag changes
// - xor result stored back into memory, only zero flag changes
// - xor immediate into work register, only zero flag changes
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module mies_core (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [mies_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [mies_pkg::DATA_W-1:0] wdata,
  input wire logic [mies_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [mies_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [mies_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import mies_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DUMMY} mies_state_t;

  mies_state_t state;
  logic [1:0] div_cnt;
  logic cyc_en;
  logic exec;
  logic busy;
  mies_op_t cmd_op;
  logic [6:0] cmd_addr;
  logic [2:0] cmd_bit;
  logic [7:0] cmd_imm;
  logic [7:0] wreg;
  logic [5:0] flags;
  logic [7:0] table_pointer;
  logic [5:0] table_high_latch;
  logic [2:0] cur_page;
  logic last_skip;
  logic [6:0] mem_sel;
  logic [10:0] prog_sel;
  logic [7:0] dmem [0:MEM_DEPTH-1];
  logic [13:0] prom [0:ROM_DEPTH-1];
  logic mem_ok;
  logic [7:0] mem_val;
  logic [2:0] page_sel;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic [32:0] wr_view;
  logic [32:0] rd_view;
  logic [31:0] wr_mask;
  logic [31:0] wr_val;
  logic wr_ok;

  mies_alu_if alu_bus ();

  mies_alu u_alu (
    .bus(alu_bus.alu)
  );

  // operand fetch; addresses past the data memory read as zero and never write
  assign mem_ok = (cmd_addr < MEM_LIMIT);
  assign mem_val = mem_ok ? dmem[cmd_addr] : BYTE_ZERO;
  assign page_sel = (cmd_op == OP_TBL_FINAL) ? FINAL_PAGE : cur_page;
  assign alu_bus.op = cmd_op;
  assign alu_bus.mem_val = mem_val;
  assign alu_bus.wreg = wreg;
  assign alu_bus.imm = cmd_imm;
  assign alu_bus.bit_sel = cmd_bit;
  assign alu_bus.flags_in = flags;
  assign alu_bus.rom_word = prom[{page_sel, table_pointer}];

  // instruction cycle divider
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      div_cnt <= 2'h0;
    else
      div_cnt <= (div_cnt == CYC_DIV_LAST) ? 2'h0 : div_cnt + 2'h1;
  end

  assign cyc_en = (div_cnt == CYC_DIV_LAST);
  assign exec = (state == ST_WAIT) && cyc_en;
  assign busy = (state != ST_IDLE);

  // sequencer: a skip holds the block busy for one extra instruction cycle
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= ST_IDLE;
    else
      case (state)
        ST_IDLE: if (wr_ok && aw_addr_q == REG_CMD) state <= ST_WAIT;
        ST_WAIT: if (cyc_en) state <= alu_bus.skip ? ST_DUMMY : ST_IDLE;
        ST_DUMMY: if (cyc_en) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
  end

  // last instruction's skip outcome, kept for software
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      last_skip <= 1'b0;
    else if (exec)
      last_skip <= alu_bus.skip;
  end

  // command latch
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd_op <= OP_SKIP_ZERO;
      cmd_addr <= 7'h00;
      cmd_bit <= 3'h0;
      cmd_imm <= 8'h00;
    end
    else if (wr_ok && aw_addr_q == REG_CMD)
    begin
      cmd_op <= mies_op_t'(wr_val[CMD_OP_LSB +: 5]);
      cmd_addr <= wr_val[CMD_ADDR_LSB +: 7];
      cmd_bit <= wr_val[CMD_BIT_LSB +: 3];
      cmd_imm <= wr_val[CMD_IMM_LSB +: 8];
    end
  end

  // work register: execution owns it while busy, software only when idle
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      wreg <= 8'h00;
    else if (exec && alu_bus.wreg_we)
      wreg <= alu_bus.result;
    else if (wr_ok && aw_addr_q == REG_WREG)
      wreg <= wr_val[7:0];
  end

  // status flags; untouched by every opcode that does not name them
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      flags <= FLAG_RESET;
    else if (exec)
      flags <= alu_bus.flags_out;
    else if (wr_ok && aw_addr_q == REG_STATUS)
      flags <= wr_val[5:0];
  end

  // table pointer, current page and table-high latch
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      table_pointer <= 8'h00;
      cur_page <= 3'h0;
      table_high_latch <= 6'h00;
    end
    else
    begin
      if (wr_ok && aw_addr_q == REG_TBL)
        table_pointer <= wr_val[7:0];
      if (wr_ok && aw_addr_q == REG_PAGE)
        cur_page <= wr_val[2:0];
      if (exec && alu_bus.tbl_we)
        table_high_latch <= alu_bus.rom_word[13:8];
    end
  end

  // window pointers into both memories
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mem_sel <= 7'h00;
      prog_sel <= 11'h000;
    end
    else
    begin
      if (wr_ok && aw_addr_q == REG_MADDR)
        mem_sel <= wr_val[6:0];
      if (wr_ok && aw_addr_q == REG_PADDR)
        prog_sel <= wr_val[10:0];
    end
  end

  // data memory; bus writes are refused while busy so the two never collide
  always_ff @(posedge ref_clk)
  begin
    if (exec && alu_bus.mem_we && mem_ok)
      dmem[cmd_addr] <= alu_bus.result;
    else if (wr_ok && aw_addr_q == REG_MDATA && mem_sel < MEM_LIMIT)
      dmem[mem_sel] <= wr_val[7:0];
  end

  // program memory is loaded by software only
  always_ff @(posedge ref_clk)
  begin
    if (wr_ok && aw_addr_q == REG_PDATA)
      prom[prog_sel] <= wr_val[13:0];
  end

  // register view: bit 32 marks a mapped, aligned offset
  function automatic logic [32:0] reg_view(input logic [7:0] a);
    logic [32:0] v;
    v = '0;
    v[32] = 1'b1;
    case (a)
      REG_CMD:
      begin
        v[CMD_OP_LSB +: 5] = cmd_op;
        v[CMD_BIT_LSB +: 3] = cmd_bit;
        v[CMD_ADDR_LSB +: 7] = cmd_addr;
        v[CMD_IMM_LSB +: 8] = cmd_imm;
      end
      REG_STATUS:
      begin
        v[5:0] = flags;
        v[STAT_BUSY] = busy;
        v[STAT_SKIP] = last_skip;
      end
      REG_WREG: v[7:0] = wreg;
      REG_TBL:
      begin
        v[7:0] = table_pointer;
        v[TBL_HIGH_LSB +: 6] = table_high_latch;
      end
      REG_PAGE: v[2:0] = cur_page;
      REG_MADDR: v[6:0] = mem_sel;
      REG_MDATA: v[7:0] = (mem_sel < MEM_LIMIT) ? dmem[mem_sel] : BYTE_ZERO;
      REG_PADDR: v[10:0] = prog_sel;
      REG_PDATA: v[13:0] = prom[prog_sel];
      default: v[32] = 1'b0;
    endcase
    return v;
  endfunction : reg_view

  // write merge honours byte strobes; unwritten lanes keep their old value
  always_comb
  begin
    wr_view = reg_view(aw_addr_q);
    rd_view = reg_view(araddr);
    for (int i = 0; i < STRB_W; i++)
      wr_mask[i*8 +: 8] = {8{w_strb_q[i]}};
    wr_val = (wr_view[31:0] & ~wr_mask) | (w_data_q & wr_mask);
  end

  assign do_write = aw_held && w_held && !bvalid;
  // a busy block refuses every write so software cannot disturb an instruction
  assign wr_ok = do_write && wr_view[32] && !busy;

  // write address channel
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awready <= 1'b0;
      aw_held <= 1'b0;
      aw_addr_q <= 8'h00;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
      end
      else if (!aw_held && !bvalid)
        awready <= 1'b1;
      if (do_write)
        aw_held <= 1'b0;
    end
  end

  // write data channel, taken independently of the address
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wready <= 1'b0;
      w_held <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else
    begin
      if (wvalid && wready)
      begin
        wready <= 1'b0;
        w_held <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      else if (!w_held && !bvalid)
        wready <= 1'b1;
      if (do_write)
        w_held <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // read channel: data captured at the address handshake
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else
    begin
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_view[31:0];
        rresp <= rd_view[32] ? RESP_OKAY : RESP_SLVERR;
      end
      else
      begin
        if (rvalid && rready)
          rvalid <= 1'b0;
        if (!rvalid)
          arready <= 1'b1;
      end
    end
  end

  default clocking a_clk @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  a_dec_wreg: assert property (exec && cmd_op == OP_DEC_W_SKIP |=> wreg == $past(mem_val) - BYTE_ONE)
    else $error("decrement result not in work register");
  a_noskip_one: assert property (exec && !alu_bus.skip |=> state == ST_IDLE)
    else $error("non-skipping instruction took more than one cycle");
  a_skip_dummy: assert property (exec && alu_bus.skip |=> state == ST_DUMMY [*4] ##1 state == ST_IDLE)
    else $error("skip did not take exactly one dummy cycle");
  a_set_fill: assert property (exec && cmd_op == OP_SET && mem_ok |=> dmem[cmd_addr] == BYTE_ONES && $stable(flags))
    else $error("set did not fill byte or changed flags");
  a_set_bit: assert property (exec && cmd_op == OP_SET_BIT && mem_ok
    |=> dmem[cmd_addr] == ($past(mem_val) | (BYTE_ONE << cmd_bit)))
    else $error("bit set altered wrong bits");
  a_inc_store: assert property (exec && cmd_op == OP_INC_SKIP && mem_ok
    |=> dmem[cmd_addr] == $past(mem_val) + BYTE_ONE && last_skip == (dmem[cmd_addr] == BYTE_ZERO))
    else $error("increment store or skip wrong");
  a_zero_test: assert property (exec && cmd_op == OP_SKIP_ZERO |=> $stable(flags) && $stable(wreg)
    && last_skip == ($past(mem_val) == BYTE_ZERO))
    else $error("zero test modified state or skipped wrongly");
  a_sub_carry: assert property (exec && cmd_op == OP_SUB
    |=> flags[FLAG_C] == ($past(wreg) >= $past(mem_val)) && wreg == $past(wreg) - $past(mem_val))
    else $error("subtract result or borrow wrong");
  a_tbl_latch: assert property (exec && cmd_op == OP_TBL_CUR
    |=> table_high_latch == $past(alu_bus.rom_word[13:8]))
    else $error("table high latch not loaded");
  a_xor_zero: assert property (exec && cmd_op == OP_XOR
    |=> wreg == ($past(wreg) ^ $past(mem_val)) && flags[FLAG_Z] == (wreg == BYTE_ZERO))
    else $error("xor result or zero flag wrong");
endmodule : mies_core

// [verification/mies_core_bench.sv]
// self-checking bench for the instruction execution block over its register bus
`timescale 1ns/100ps
module mies_core_bench;
  import mies_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [1:0] rs;

  // full-word writes only, so the strobes stay tied high
  mies_core u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  // 250 MHz clock
  initial
    forever #2 ref_clk = ~ref_clk;

  // hang guard, far above the fewer than two thousand cycles the run needs
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      stop_test;
    end
  end

  task automatic stop_test;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rdr

  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rs);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
  endtask : wok

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rdr(a, rd, rs);
    chk(rd, exp);
  endtask : rchk

  // busy is polled, never timed, so the check holds whatever the divider phase
  task automatic wait_idle;
    do
      rdr(REG_STATUS, rd, rs);
    while (rd[STAT_BUSY] !== 1'b0);
  endtask : wait_idle

  // expected {overflow, zero, half carry, carry, result} of a minus b
  function automatic logic [11:0] sub_calc(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, ~b} + 9'h001;
    h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    return {(a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction : sub_calc

  // load operands, run one instruction, then check memory, work register and status
  task automatic run_op(input mies_op_t op, input logic [6:0] ad, input logic [2:0] bn, input logic [7:0] imm,
                        input logic [7:0] m, input logic [7:0] w, input logic [5:0] fl,
                        input logic [7:0] em, input logic [7:0] ew, input logic [5:0] ef, input logic sk);
    wok(REG_MADDR, {25'h0, ad});
    wok(REG_MDATA, {24'h0, m});
    wok(REG_WREG, {24'h0, w});
    wok(REG_STATUS, {26'h0, fl});
    wok(REG_CMD, {3'h0, op, 5'h00, bn, 1'b0, ad, imm});
    wait_idle;
    rchk(REG_MDATA, {24'h0, em});
    rchk(REG_WREG, {24'h0, ew});
    rchk(REG_STATUS, {22'h0, sk, 3'h0, ef});
  endtask : run_op

  task automatic t_reset;
    rchk(REG_STATUS, 32'h0);
    rchk(REG_WREG, 32'h0);
    rchk(REG_TBL, 32'h0);
  endtask : t_reset

  task automatic t_dec_set;
    run_op(OP_DEC_W_SKIP, 7'h03, 3'h0, 8'h00, 8'h05, 8'haa, 6'h2a, 8'h05, 8'h04, 6'h2a, 1'b0);
    run_op(OP_DEC_W_SKIP, 7'h03, 3'h0, 8'h00, 8'h01, 8'haa, 6'h15, 8'h01, 8'h00, 6'h15, 1'b1);
    run_op(OP_SET, 7'h57, 3'h0, 8'h00, 8'h12, 8'h33, 6'h3f, 8'hff, 8'h33, 6'h3f, 1'b0);
    run_op(OP_SET_BIT, 7'h00, 3'h7, 8'h00, 8'h00, 8'h33, 6'h2a, 8'h80, 8'h33, 6'h2a, 1'b0);
    run_op(OP_SET_BIT, 7'h00, 3'h0, 8'h00, 8'h5a, 8'h33, 6'h15, 8'h5b, 8'h33, 6'h15, 1'b0);
  endtask : t_dec_set

  task automatic t_inc;
    run_op(OP_INC_SKIP, 7'h08, 3'h0, 8'h00, 8'hff, 8'h11, 6'h2a, 8'h00, 8'h11, 6'h2a, 1'b1);
    run_op(OP_INC_SKIP, 7'h08, 3'h0, 8'h00, 8'h7f, 8'h11, 6'h2a, 8'h80, 8'h11, 6'h2a, 1'b0);
    run_op(OP_INC_W_SKIP, 7'h09, 3'h0, 8'h00, 8'hff, 8'h11, 6'h15, 8'hff, 8'h00, 6'h15, 1'b1);
    run_op(OP_INC_W_SKIP, 7'h09, 3'h0, 8'h00, 8'h41, 8'h11, 6'h15, 8'h41, 8'h42, 6'h15, 1'b0);
  endtask : t_inc

  task automatic t_tests;
    run_op(OP_SKIP_BIT_SET, 7'h0a, 3'h3, 8'h00, 8'h08, 8'h77, 6'h3f, 8'h08, 8'h77, 6'h3f, 1'b1);
    run_op(OP_SKIP_BIT_SET, 7'h0a, 3'h3, 8'h00, 8'hf7, 8'h77, 6'h3f, 8'hf7, 8'h77, 6'h3f, 1'b0);
    run_op(OP_SKIP_BIT_CLR, 7'h0b, 3'h0, 8'h00, 8'hfe, 8'h77, 6'h2a, 8'hfe, 8'h77, 6'h2a, 1'b1);
    run_op(OP_SKIP_BIT_CLR, 7'h0b, 3'h0, 8'h00, 8'h01, 8'h77, 6'h2a, 8'h01, 8'h77, 6'h2a, 1'b0);
    run_op(OP_SKIP_ZERO, 7'h0c, 3'h0, 8'h00, 8'h00, 8'h77, 6'h15, 8'h00, 8'h77, 6'h15, 1'b1);
    run_op(OP_SKIP_ZERO, 7'h0c, 3'h0, 8'h00, 8'h40, 8'h77, 6'h15, 8'h40, 8'h77, 6'h15, 1'b0);
    run_op(OP_LOAD_SKIP, 7'h0d, 3'h0, 8'h00, 8'h00, 8'h77, 6'h2a, 8'h00, 8'h00, 6'h2a, 1'b1);
    run_op(OP_LOAD_SKIP, 7'h0d, 3'h0, 8'h00, 8'h9a, 8'h77, 6'h2a, 8'h9a, 8'h9a, 6'h2a, 1'b0);
  endtask : t_tests

  // borrow, no borrow, signed overflow both ways and a zero result
  task automatic t_sub;
    logic [7:0] ws [5] = '{8'h05, 8'h03, 8'h80, 8'h7f, 8'h44};
    logic [7:0] ms [5] = '{8'h03, 8'h05, 8'h01, 8'hff, 8'h44};
    logic [11:0] f;
    for (int i = 0; i < 5; i++)
    begin
      f = sub_calc(ws[i], ms[i]);
      run_op(OP_SUB, 7'h10, 3'h0, 8'h00, ms[i], ws[i], 6'h30, ms[i], f[7:0], {2'b11, f[11:8]}, 1'b0);
      run_op(OP_SUB_STORE, 7'h11, 3'h0, 8'h00, ms[i], ws[i], 6'h30, f[7:0], ws[i], {2'b11, f[11:8]}, 1'b0);
      run_op(OP_SUB_IMM, 7'h12, 3'h0, ms[i], 8'h00, ws[i], 6'h30, 8'h00, f[7:0], {2'b11, f[11:8]}, 1'b0);
    end
  endtask : t_sub

  task automatic t_swap_xor;
    run_op(OP_SWAP, 7'h20, 3'h0, 8'h00, 8'ha5, 8'h00, 6'h3f, 8'h5a, 8'h00, 6'h3f, 1'b0);
    run_op(OP_SWAP_W, 7'h21, 3'h0, 8'h00, 8'hc3, 8'h00, 6'h2a, 8'hc3, 8'h3c, 6'h2a, 1'b0);
    run_op(OP_XOR, 7'h22, 3'h0, 8'h00, 8'h3c, 8'h0f, 6'h0b, 8'h3c, 8'h33, 6'h0b, 1'b0);
    run_op(OP_XOR, 7'h22, 3'h0, 8'h00, 8'h5a, 8'h5a, 6'h0b, 8'h5a, 8'h00, 6'h0f, 1'b0);
    run_op(OP_XOR_STORE, 7'h23, 3'h0, 8'h00, 8'h3c, 8'h0f, 6'h3c, 8'h33, 8'h0f, 6'h38, 1'b0);
    run_op(OP_XOR_IMM, 7'h24, 3'h0, 8'h0f, 8'h99, 8'h0f, 6'h0b, 8'h99, 8'h00, 6'h0f, 1'b0);
  endtask : t_swap_xor

  // program page 3 and the final page hold different words at the same pointer
  task automatic t_table;
    wok(REG_PAGE, 32'h3);
    wok(REG_TBL, 32'h41);
    wok(REG_PADDR, 32'h341);
    wok(REG_PDATA, 32'h2c7e);
    wok(REG_PADDR, 32'h741);
    wok(REG_PDATA, 32'h1234);
    run_op(OP_TBL_CUR, 7'h30, 3'h0, 8'h00, 8'h00, 8'h66, 6'h2a, 8'h7e, 8'h66, 6'h2a, 1'b0);
    rchk(REG_TBL, 32'h2c41);
    run_op(OP_TBL_FINAL, 7'h31, 3'h0, 8'h00, 8'h00, 8'h66, 6'h15, 8'h34, 8'h66, 6'h15, 1'b0);
    rchk(REG_TBL, 32'h1241);
  endtask : t_table

  // refusals: unmapped, misaligned, memory beyond its end, write while busy
  task automatic t_bus;
    rdr(8'h24, rd, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    chk(rd, 32'h0);
    wr(8'h02, 32'h5, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    wok(REG_MADDR, 32'h60);
    wok(REG_MDATA, 32'h55);
    rchk(REG_MDATA, 32'h0);
    wok(REG_WREG, 32'h11);
    wok(REG_MADDR, 32'h05);
    wok(REG_MDATA, 32'h00);
    wok(REG_CMD, {3'h0, OP_SKIP_ZERO, 8'h00, 8'h05, 8'h00});
    wr(REG_WREG, 32'h22, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    wait_idle;
    rchk(REG_WREG, 32'h11);
  endtask : t_bus

  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset;
    t_dec_set;
    t_inc;
    t_tests;
    t_sub;
    t_swap_xor;
    t_table;
    t_bus;
    stop_test;
  end
endmodule : mies_core_bench
